// File: lcp_link_ctl2_pm_cap_regs.sv
// Module: second-generation link/slot registers and power management header of one port
`timescale 1ns/1ps
module lcp_link_ctl2_pm_cap_regs
	import lcp_pkg::*;
#(
	parameter logic [1:0] SUPPORTED_MASK = MASK_GEN1
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr_strobe,
	input  wire logic              rd_strobe,
	output logic [31:0]            rdata,
	input  wire logic              port_downstream,
	input  wire logic              legacy_mode,
	input  wire logic              cfg_unlock,
	input  wire logic              hot_reset,
	input  wire logic              speed_change_req,
	input  wire logic              speed_change_lower,
	input  wire logic              link_unreliable,
	output logic [3:0]             target_speed,
	output logic                   enter_compliance,
	output logic                   autonomous_speed_disable,
	output logic [1:0]             adv_speed_mask,
	output logic                   compliance_go,
	output logic [3:0]             compliance_speed,
	output logic                   speed_change_grant
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Registers are word-wide; the 16-bit pairs share one word
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction

	lcp_regs_t r;
	lcp_regs_t next_r;

	logic [15:0] ctl2_view;
	logic [31:0] pm_view;
	logic [31:0] read_value;

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------
	always_comb begin
		ctl2_view = 16'h0000;
		if (!legacy_mode) begin
			ctl2_view[TS_MSB:TS_LSB] = r.target_speed;
			ctl2_view[EC_BIT]        = r.enter_compliance;
			ctl2_view[ASD_BIT]       = r.autonomous_speed_disable;
		end
	end

	always_comb begin
		pm_view = ZERO_WORD;
		pm_view[CAPABILITY_IDENTIFIER_MSB:CAPABILITY_IDENTIFIER_LSB] = CAPABILITY_IDENTIFIER_PM;
		pm_view[NXT_MSB:NXT_LSB]     = r.next_capability_pointer;
		pm_view[VER_MSB:VER_LSB]     = PM_VERSION;
		pm_view[DSI_BIT]             = r.device_specific_init_flag;
	end

	always_comb begin
		read_value = ZERO_WORD;
		if (hit(addr, OFF_LINK_CONTROL_SECOND)) begin
			// Status half stays reserved
			read_value = {16'h0000, ctl2_view};
		end else if (hit(addr, OFF_POWER_MGMT_CAP_HEADER)) begin
			read_value = pm_view;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		// Read data stand for one cycle only
		next_r.rdata = rd_strobe ? read_value : ZERO_WORD;
		if (wr_strobe && hit(addr, OFF_LINK_CONTROL_SECOND) && !legacy_mode) begin
			// Any code is stored; only the SPEED_GEN1 and SPEED_GEN2 codes are meaningful
			next_r.target_speed             = wdata[TS_MSB:TS_LSB];
			next_r.enter_compliance         = wdata[EC_BIT];
			next_r.autonomous_speed_disable = wdata[ASD_BIT];
		end
		if (wr_strobe && hit(addr, OFF_POWER_MGMT_CAP_HEADER) && cfg_unlock) begin
			next_r.next_capability_pointer   = wdata[NXT_MSB:NXT_LSB];
			next_r.device_specific_init_flag = wdata[DSI_BIT];
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Port role is sampled while reset is high
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r.target_speed              <= TS_RESET;
			r.enter_compliance          <= 1'b0;
			r.autonomous_speed_disable  <= 1'b0;
			r.next_capability_pointer   <= port_downstream ? NXT_DOWNSTREAM : NXT_UPSTREAM;
			r.device_specific_init_flag <= 1'b0;
			r.downstream                <= port_downstream;
			r.rdata                     <= ZERO_WORD;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign rdata = r.rdata;

	// ----------------------------------------------------------------
	// Link controls
	// ----------------------------------------------------------------
	lcp_link_if lnk ();

	// Legacy mode hides target speed, compliance and speed disable from the link; the port role still passes
	assign lnk.target_speed             = legacy_mode ? TS_RESET : r.target_speed;
	assign lnk.enter_compliance         = !legacy_mode && r.enter_compliance;
	assign lnk.autonomous_speed_disable = !legacy_mode && r.autonomous_speed_disable;
	assign lnk.downstream               = r.downstream;

	assign target_speed             = lnk.target_speed;
	assign enter_compliance         = lnk.enter_compliance;
	assign autonomous_speed_disable = lnk.autonomous_speed_disable;

	lcp_speed_policy #(
		.SUPPORTED_MASK (SUPPORTED_MASK)
	) u_policy (
		.clk_sys            (clk_sys),
		.reset              (reset),
		.ce                 (ce),
		.lnk                (lnk),
		.hot_reset          (hot_reset),
		.speed_change_req   (speed_change_req),
		.speed_change_lower (speed_change_lower),
		.link_unreliable    (link_unreliable),
		.adv_speed_mask     (adv_speed_mask),
		.compliance_go      (compliance_go),
		.compliance_speed   (compliance_speed),
		.speed_change_grant (speed_change_grant)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	rdata_one_cycle_a: assert property (
		ce && !rd_strobe |=> rdata == ZERO_WORD)
		else $error("read data present without a read");

	capability_identifier_fixed_a: assert property (
		ce && rd_strobe && hit(addr, OFF_POWER_MGMT_CAP_HEADER)
			|=> rdata[CAPABILITY_IDENTIFIER_MSB:CAPABILITY_IDENTIFIER_LSB] == CAPABILITY_IDENTIFIER_PM)
		else $error("capability identifier wrong");

	pm_version_a: assert property (
		ce && rd_strobe && hit(addr, OFF_POWER_MGMT_CAP_HEADER)
			|=> rdata[VER_MSB:VER_LSB] == PM_VERSION)
		else $error("pm version wrong");

	pm_zero_bits_a: assert property (
		ce && rd_strobe && hit(addr, OFF_POWER_MGMT_CAP_HEADER)
			|=> rdata[24:22] == 3'h0 && rdata[19] == 1'b0 && rdata[31:25] == 7'h00)
		else $error("wake clock or aux current not zero");

	next_ptr_reset_a: assert property (
		$past(reset) |-> r.next_capability_pointer
			== ($past(port_downstream) ? NXT_DOWNSTREAM : NXT_UPSTREAM))
		else $error("next pointer reset value wrong");

	dsi_reset_a: assert property (
		$past(reset) |-> !r.device_specific_init_flag)
		else $error("device init flag not cleared");

	dsi_locked_a: assert property (
		ce && !cfg_unlock |=> $stable(r.device_specific_init_flag)
			&& $stable(r.next_capability_pointer))
		else $error("lockable field changed while locked");

	legacy_zero_a: assert property (
		ce && rd_strobe && legacy_mode && hit(addr, OFF_LINK_CONTROL_SECOND)
			|=> rdata == ZERO_WORD)
		else $error("link control visible in legacy mode");

	legacy_hold_a: assert property (
		ce && legacy_mode |=> $stable(r.target_speed) && $stable(r.enter_compliance)
			&& $stable(r.autonomous_speed_disable))
		else $error("link control written in legacy mode");

	ctl_reserved_a: assert property (
		ce && rd_strobe && hit(addr, OFF_LINK_CONTROL_SECOND)
			|=> rdata[31:6] == 26'h0)
		else $error("reserved link control bits not zero");

	ctl_write_a: assert property (
		ce && wr_strobe && !legacy_mode && hit(addr, OFF_LINK_CONTROL_SECOND)
			|=> r.target_speed == $past(wdata[TS_MSB:TS_LSB])
			&& r.enter_compliance == $past(wdata[EC_BIT]))
		else $error("link control write lost");

	reserved_reg_a: assert property (
		ce && rd_strobe && (hit(addr, OFF_LINK_CAPABILITIES_SECOND)
			|| hit(addr, OFF_SLOT_CAPABILITIES_SECOND)
			|| hit(addr, OFF_SLOT_CONTROL_SECOND)) |=> rdata == ZERO_WORD)
		else $error("reserved register not zero");

	cover_ctl_write_c: cover property (
		ce && wr_strobe && hit(addr, OFF_LINK_CONTROL_SECOND) && !legacy_mode);
	cover_pm_read_c: cover property (
		ce && rd_strobe && hit(addr, OFF_POWER_MGMT_CAP_HEADER));
	cover_unlock_c: cover property (
		ce && wr_strobe && cfg_unlock && hit(addr, OFF_POWER_MGMT_CAP_HEADER));

endmodule

// File: lcp_link_ctl2_pm_cap_regs_test.sv
// Testbench: link control, reserved words and power management header of one port
`timescale 1ns/1ps
module lcp_link_ctl2_pm_cap_regs_test
	import lcp_pkg::*;
();
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic              clk_sys, reset, ce, wr_strobe, rd_strobe;
	logic              port_downstream, legacy_mode, cfg_unlock, hot_reset;
	logic              speed_change_req, speed_change_lower, link_unreliable;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        target_speed, compliance_speed;
	logic              enter_compliance, autonomous_speed_disable;
	logic [1:0]        adv_speed_mask;
	logic              compliance_go, speed_change_grant;
	int                n_mismatch, checks_done;

	// Both speeds supported so the downstream cap is visible on the mask
	lcp_link_ctl2_pm_cap_regs #(.SUPPORTED_MASK(MASK_GEN1_GEN2)) u_dut (
		.clk_sys(clk_sys), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.port_downstream(port_downstream), .legacy_mode(legacy_mode),
		.cfg_unlock(cfg_unlock), .hot_reset(hot_reset),
		.speed_change_req(speed_change_req), .speed_change_lower(speed_change_lower),
		.link_unreliable(link_unreliable), .target_speed(target_speed),
		.enter_compliance(enter_compliance),
		.autonomous_speed_disable(autonomous_speed_disable),
		.adv_speed_mask(adv_speed_mask), .compliance_go(compliance_go),
		.compliance_speed(compliance_speed), .speed_change_grant(speed_change_grant));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clk_sys);
		wr_strobe <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk_sys);
		rd_strobe <= 1'b0;
		#1 chk(name, e, rdata);
	endtask

	task automatic do_reset(input logic down);
		port_downstream <= down;
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		logic [ADDR_W-1:0] offs [6] = '{12'h06c, 12'h070, 12'h072, 12'h074, 12'h078, 12'h07a};
		foreach (offs[i]) rd_chk("zero word", offs[i], 32'h0000_0000);
		rd_chk("pm header", 12'h0c0, 32'h0003_d001);
		@(posedge clk_sys);
		#1 chk("rdata after read", 32'h0, rdata);
		chk("mask at reset", 32'h3, adv_speed_mask);
	endtask

	task automatic t_target();
		logic [3:0] sp [2] = '{4'h1, 4'h2};
		logic [1:0] mk [2] = '{2'h1, 2'h3};
		foreach (sp[i]) begin
			wr(12'h070, {28'h0, sp[i]} | 32'h20);
			@(posedge clk_sys);
			#1 chk("target speed", sp[i], target_speed);
			chk("speed disable", 32'h1, autonomous_speed_disable);
			chk("advertised mask", mk[i], adv_speed_mask);
		end
		wr(12'h070, 32'hffff_ffc1);
		rd_chk("ctl2 reserved", 12'h070, 32'h0000_0001);
		rd_chk("status2 word", 12'h072, 32'h0000_0001);
	endtask

	task automatic t_compliance();
		logic [31:0] d [3] = '{32'h01, 32'h11, 32'h12};
		logic [3:0]  s [3] = '{4'h0, 4'h1, 4'h2};
		foreach (d[i]) begin
			wr(12'h070, d[i]);
			hot_reset <= 1'b1;
			@(posedge clk_sys);
			hot_reset <= 1'b0;
			#1 chk("compliance go", {31'h0, d[i][4]}, compliance_go);
			chk("compliance speed", s[i], compliance_speed);
			@(posedge clk_sys);
			#1 chk("compliance go end", 32'h0, compliance_go);
		end
	endtask

	task automatic t_grant();
		logic [1:0] cond [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
		wr(12'h070, 32'h21);
		foreach (cond[i]) begin
			@(posedge clk_sys);
			speed_change_req <= 1'b1;
			{speed_change_lower, link_unreliable} <= cond[i];
			#1 chk("grant disabled", {31'h0, &cond[i]}, speed_change_grant);
		end
		wr(12'h070, 32'h01);
		{speed_change_lower, link_unreliable} <= 2'b00;
		#1 chk("grant enabled", 32'h1, speed_change_grant);
		speed_change_req <= 1'b0;
	endtask

	task automatic t_legacy();
		wr(12'h070, 32'h31);
		legacy_mode <= 1'b1;
		@(posedge clk_sys);
		@(posedge clk_sys);
		#1 chk("legacy fields", 32'h0,
			{target_speed, enter_compliance, autonomous_speed_disable});
		rd_chk("legacy read", 12'h070, 32'h0);
		wr(12'h070, 32'h12);
		legacy_mode <= 1'b0;
		rd_chk("legacy write ignored", 12'h070, 32'h31);
		ce <= 1'b0;
		wr(12'h070, 32'h02);
		ce <= 1'b1;
		rd_chk("ce low ignored", 12'h070, 32'h31);
	endtask

	task automatic t_pm_and_reserved();
		logic [ADDR_W-1:0] offs [5] = '{12'h06c, 12'h074, 12'h078, 12'h07a, 12'h100};
		wr(12'h0c0, 32'hffff_ffff);
		rd_chk("pm locked", 12'h0c0, 32'h0003_d001);
		cfg_unlock <= 1'b1;
		wr(12'h0c0, 32'hffff_ffff);
		cfg_unlock <= 1'b0;
		rd_chk("pm unlocked", 12'h0c0, 32'h0023_ff01);
		foreach (offs[i]) begin
			wr(offs[i], 32'hffff_ffff);
			rd_chk("reserved write", offs[i], 32'h0);
		end
		do_reset(1'b0);
		rd_chk("pm upstream", 12'h0c0, 32'h0003_0001);
		wr(12'h070, 32'h01);
		@(posedge clk_sys);
		#1 chk("upstream mask", 32'h3, adv_speed_mask);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{reset, wr_strobe, rd_strobe, legacy_mode, cfg_unlock, hot_reset} = '0;
		{speed_change_req, speed_change_lower, link_unreliable} = '0;
		ce = 1'b1;
		port_downstream = 1'b1;
		addr = '0;
		wdata = '0;
		n_mismatch = 0;
		checks_done = 0;
		do_reset(1'b1);
		t_reset_values();
		t_target();
		t_compliance();
		t_grant();
		t_legacy();
		t_pm_and_reserved();
		print_verdict();
	end

	initial begin
		repeat (4000) @(posedge clk_sys);
		n_mismatch++;
		print_verdict();
	end
endmodule

// File: lcp_link_if.sv
// Interface: live link controls passed from the register bank to the speed policy
`timescale 1ns/1ps
interface lcp_link_if;
	logic [3:0] target_speed;
	logic       enter_compliance;
	logic       autonomous_speed_disable;
	logic       downstream;

	modport regs (
		output target_speed,
		output enter_compliance,
		output autonomous_speed_disable,
		output downstream
	);
	modport policy (
		input target_speed,
		input enter_compliance,
		input autonomous_speed_disable,
		input downstream
	);
endinterface

// File: lcp_pkg.sv
// Package: offsets, field layout, reset values and state types of the link/pm register slice
package lcp_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_LINK_CAPABILITIES_SECOND = 12'h06c;
	localparam logic [ADDR_W-1:0] OFF_LINK_CONTROL_SECOND      = 12'h070;
	localparam logic [ADDR_W-1:0] OFF_LINK_STATUS_SECOND       = 12'h072;
	localparam logic [ADDR_W-1:0] OFF_SLOT_CAPABILITIES_SECOND = 12'h074;
	localparam logic [ADDR_W-1:0] OFF_SLOT_CONTROL_SECOND      = 12'h078;
	localparam logic [ADDR_W-1:0] OFF_SLOT_STATUS_SECOND       = 12'h07a;
	localparam logic [ADDR_W-1:0] OFF_POWER_MGMT_CAP_HEADER    = 12'h0c0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TS_LSB    = 0;
	localparam int TS_MSB    = 3;
	localparam int EC_BIT    = 4;
	localparam int ASD_BIT   = 5;
	localparam int CAPABILITY_IDENTIFIER_LSB = 0;
	localparam int CAPABILITY_IDENTIFIER_MSB = 7;
	localparam int NXT_LSB   = 8;
	localparam int NXT_MSB   = 15;
	localparam int VER_LSB   = 16;
	localparam int VER_MSB   = 18;
	localparam int DSI_BIT   = 21;
	localparam int HALF_W    = 16;

	// ----------------------------------------------------------------
	// Encodings and fixed values
	// ----------------------------------------------------------------
	localparam logic [3:0]  SPEED_GEN1      = 4'h1;
	localparam logic [3:0]  SPEED_GEN2      = 4'h2;
	localparam logic [1:0]  MASK_GEN1       = 2'h1;
	localparam logic [1:0]  MASK_GEN1_GEN2  = 2'h3;
	localparam logic [7:0]  CAPABILITY_IDENTIFIER_PM        = 8'h01;
	localparam logic [7:0]  NXT_UPSTREAM    = 8'h00;
	localparam logic [7:0]  NXT_DOWNSTREAM  = 8'hd0;
	localparam logic [2:0]  PM_VERSION      = 3'h3;
	localparam logic [3:0]  TS_RESET        = 4'h0;
	localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

	// ----------------------------------------------------------------
	// State records
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  target_speed;
		logic        enter_compliance;
		logic        autonomous_speed_disable;
		logic [7:0]  next_capability_pointer;
		logic        device_specific_init_flag;
		logic        downstream;
		logic [31:0] rdata;
	} lcp_regs_t;

	typedef struct packed {
		logic [1:0] adv_speed_mask;
		logic       compliance_go;
		logic [3:0] compliance_speed;
	} lcp_pol_t;

endpackage

// File: lcp_speed_policy.sv
// Module: speed advertisement, compliance entry and autonomous speed-change gating
`timescale 1ns/1ps
module lcp_speed_policy
	import lcp_pkg::*;
#(
	parameter logic [1:0] SUPPORTED_MASK = MASK_GEN1
) (
	input  wire logic     clk_sys,
	input  wire logic     reset,
	input  wire logic     ce,
	lcp_link_if.policy    lnk,
	input  wire logic     hot_reset,
	input  wire logic     speed_change_req,
	input  wire logic     speed_change_lower,
	input  wire logic     link_unreliable,
	output logic [1:0]    adv_speed_mask,
	output logic          compliance_go,
	output logic [3:0]    compliance_speed,
	output logic          speed_change_grant
);

	// ----------------------------------------------------------------
	// Speed decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] speed_cap(input logic [3:0] ts);
		case (ts)
			SPEED_GEN1: speed_cap = MASK_GEN1;
			SPEED_GEN2: speed_cap = MASK_GEN1_GEN2;
			default:    speed_cap = MASK_GEN1_GEN2;
		endcase
	endfunction

	lcp_pol_t r;
	lcp_pol_t next_r;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		// Downstream ports cap what is advertised; upstream ports offer all
		if (lnk.downstream) begin
			next_r.adv_speed_mask = speed_cap(lnk.target_speed) & SUPPORTED_MASK;
		end else begin
			next_r.adv_speed_mask = SUPPORTED_MASK;
		end
		next_r.compliance_go = hot_reset && lnk.enter_compliance;
		if (hot_reset && lnk.enter_compliance) begin
			next_r.compliance_speed = lnk.target_speed;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r <= '{adv_speed_mask: SUPPORTED_MASK, compliance_go: 1'b0,
				compliance_speed: TS_RESET};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign adv_speed_mask   = r.adv_speed_mask;
	assign compliance_go    = r.compliance_go;
	assign compliance_speed = r.compliance_speed;
	// Only a downward fix for an unreliable link passes while disabled
	assign speed_change_grant = speed_change_req &&
		(!lnk.autonomous_speed_disable || (speed_change_lower && link_unreliable));

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	adv_cap_gen1_a: assert property (@(posedge clk_sys) disable iff (reset)
		ce && lnk.downstream && lnk.target_speed == SPEED_GEN1 |=> adv_speed_mask == MASK_GEN1)
		else $error("advertised speeds not capped to target");
	comp_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
		ce && hot_reset && lnk.enter_compliance |=> compliance_go
			&& compliance_speed == $past(lnk.target_speed))
		else $error("compliance not entered at target speed");
	comp_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		ce && !hot_reset |=> !compliance_go && $stable(compliance_speed))
		else $error("compliance pulse without hot reset");
	asd_block_a: assert property (@(posedge clk_sys) disable iff (reset)
		lnk.autonomous_speed_disable && !(speed_change_lower && link_unreliable)
			|-> !speed_change_grant)
		else $error("autonomous speed change while disabled");
	cover_comp_c: cover property (@(posedge clk_sys) disable iff (reset) compliance_go);
	cover_fix_c: cover property (@(posedge clk_sys) disable iff (reset)
		lnk.autonomous_speed_disable && speed_change_grant);

endmodule
